// file: hdl/scs_pkg.sv
// Types shared by the serial clock synthesizer configuration block
package scs_pkg;
  typedef logic [23:0] scs_word_t;
  typedef logic [1:0]  scs_func_t;
  typedef logic [2:0]  scs_odsel_t;
  typedef enum logic [1:0] {
    SCS_F_REF,
    SCS_F_REF_HALF,
    SCS_F_OFF,
    SCS_F_PRI_HALF
  } scs_second_fn_t;
endpackage

// file: hdl/scs_map.svh
// Field positions, defaults and timing counts of the configuration word
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH
`define SCS_WORD_BITS     24
`define SCS_CLOAD_HI      23
`define SCS_CLOAD_LO      22
`define SCS_DUTY_BIT      21
`define SCS_FUNC_HI       20
`define SCS_FUNC_LO       19
`define SCS_OD_HI         18
`define SCS_OD_LO         16
`define SCS_FB_HI         15
`define SCS_FB_LO         7
`define SCS_REF_HI        6
`define SCS_REF_LO        0
`define SCS_DEFAULT_WORD  24'h238406
`define SCS_CLK_PERIOD_NS 25
`define SCS_GLIDE_TIME_NS 1000000
`define SCS_LOCK_TIME_NS  10000000
`define SCS_GLIDE_CYCLES  (`SCS_GLIDE_TIME_NS / `SCS_CLK_PERIOD_NS)
`define SCS_LOCK_CYCLES   (`SCS_LOCK_TIME_NS / `SCS_CLK_PERIOD_NS)
`endif

// file: hdl/scs_clk_div.sv
// Programmable clock divider producing an enable-free toggling output
`timescale 1ns/1ps
module scs_clk_div #(
  parameter int W = 8
) (
  input  wire logic         clk_i,   // System clock
  input  wire logic         rst_i,   // Sync reset
  input  wire logic         run_i,   // Count enable
  input  wire logic [W-1:0] ratio_i, // Divide ratio, 0 and 1 pass through
  input  wire logic         src_i,   // Source tick, one per source edge
  output logic              tick_o,  // Divided tick pulse
  output logic              lvl_o    // Divided square level
);
  logic [W-1:0] cnt_ff;
  logic         lvl_ff;
  logic         hit;

  assign hit    = src_i && (cnt_ff + W'(1) >= ratio_i);
  assign tick_o = run_i && hit;
  assign lvl_o  = lvl_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt_ff <= '0;
    end else if (hit) begin
      cnt_ff <= '0;
    end else if (src_i) begin
      cnt_ff <= cnt_ff + W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      lvl_ff <= 1'b0;
    end else if (hit) begin
      lvl_ff <= ~lvl_ff;
    end
  end
endmodule

// file: hdl/scs_synth_config.sv
// Serial programming port, configuration latch and output clock control
`timescale 1ns/1ps
`include "scs_map.svh"
module scs_synth_config #(
  parameter int GLIDE_CYCLES = `SCS_GLIDE_CYCLES,
  parameter int LOCK_CYCLES  = `SCS_LOCK_CYCLES
) (
  input  wire logic           clk_i,                 // 40 MHz system clock
  input  wire logic           rst_i,                 // Sync reset, power-up event
  input  wire logic           sclk_i,                // Serial clock pin
  input  wire logic           sdata_i,               // Serial data pin
  input  wire logic           strobe_i,              // Strobe pin
  input  wire logic           power_down_tristate_n, // Power-down, active low
  input  wire logic           ref_clk_i,             // Reference tick, one per ref edge
  output scs_pkg::scs_word_t  cfg_word_o,            // Latched configuration
  output logic [6:0]          reference_divider_word,// Active input divider
  output logic [8:0]          feedback_divider_word, // Active feedback divider
  output scs_pkg::scs_odsel_t output_divide_select,  // Active divider select
  output logic [3:0]          out_ratio_o,           // Decoded primary ratio
  output logic [1:0]          crystal_load_select,   // Crystal load setting
  output logic                duty_thresh_o,         // Duty threshold bit
  output scs_pkg::scs_func_t  second_output_function,// Secondary function
  output logic                pll_bypass_o,          // PLL bypassed
  output logic                gliding_o,             // Frequency glide active
  output logic                locked_o,              // Primary locked
  output logic                primary_clock_out,     // Primary clock
  output logic                primary_clock_oe_o,    // Primary output enable
  output logic                secondary_clock_out,   // Secondary clock
  output logic                secondary_clock_oe_o   // Secondary output enable
);
  import scs_pkg::*;

  // ----------------------------------------
  // Serial shift register
  // ----------------------------------------
  scs_word_t shift_ff;
  scs_word_t cfg_ff;
  logic      sclk_d_ff;
  logic      strobe_d_ff;
  logic      sclk_rise;
  logic      strobe_rise;

  assign sclk_rise   = sclk_i && !sclk_d_ff;
  assign strobe_rise = strobe_i && !strobe_d_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_d_ff   <= 1'b0;
      strobe_d_ff <= 1'b0;
    end else begin
      sclk_d_ff   <= sclk_i;
      strobe_d_ff <= strobe_i;
    end
  end

  // Shifting ignores power-down state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_ff <= '0;
    end else if (sclk_rise) begin
      shift_ff <= {shift_ff[`SCS_WORD_BITS-2:0], sdata_i};
    end
  end

  // ----------------------------------------
  // Configuration latch
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_ff <= `SCS_DEFAULT_WORD;
    end else if (strobe_rise) begin
      cfg_ff <= shift_ff;
    end else if (strobe_i && sclk_rise) begin
      cfg_ff <= {shift_ff[`SCS_WORD_BITS-2:0], sdata_i};
    end
  end

  logic cfg_changed;
  logic freq_changed;
  assign cfg_changed  = cfg_ff != cfg_word_o;
  assign freq_changed = (cfg_ff[`SCS_REF_HI:`SCS_REF_LO] != reference_divider_word)
                     || (cfg_ff[`SCS_FB_HI:`SCS_FB_LO] != feedback_divider_word)
                     || (cfg_ff[`SCS_DUTY_BIT] != duty_thresh_o)
                     || (cfg_ff[`SCS_CLOAD_HI:`SCS_CLOAD_LO] != crystal_load_select);

  // ----------------------------------------
  // Field decode, fields from flip-flops, out_ratio_o and pll_bypass_o decoded from them
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_word_o             <= `SCS_DEFAULT_WORD;
      reference_divider_word <= 7'(`SCS_DEFAULT_WORD >> `SCS_REF_LO);
      feedback_divider_word  <= 9'(`SCS_DEFAULT_WORD >> `SCS_FB_LO);
      output_divide_select   <= 3'(`SCS_DEFAULT_WORD >> `SCS_OD_LO);
      crystal_load_select    <= 2'(`SCS_DEFAULT_WORD >> `SCS_CLOAD_LO);
      duty_thresh_o          <= 1'(`SCS_DEFAULT_WORD >> `SCS_DUTY_BIT);
      second_output_function <= 2'(`SCS_DEFAULT_WORD >> `SCS_FUNC_LO);
    end else begin
      cfg_word_o             <= cfg_ff;
      reference_divider_word <= cfg_ff[`SCS_REF_HI:`SCS_REF_LO];
      feedback_divider_word  <= cfg_ff[`SCS_FB_HI:`SCS_FB_LO];
      output_divide_select   <= cfg_ff[`SCS_OD_HI:`SCS_OD_LO];
      crystal_load_select    <= cfg_ff[`SCS_CLOAD_HI:`SCS_CLOAD_LO];
      duty_thresh_o          <= cfg_ff[`SCS_DUTY_BIT];
      second_output_function <= cfg_ff[`SCS_FUNC_HI:`SCS_FUNC_LO];
    end
  end

  always_comb begin
    case (output_divide_select)
      3'h0:    out_ratio_o = 4'hA;
      3'h1:    out_ratio_o = 4'h2;
      3'h2:    out_ratio_o = 4'h8;
      3'h3:    out_ratio_o = 4'h4;
      3'h4:    out_ratio_o = 4'h5;
      3'h5:    out_ratio_o = 4'h7;
      3'h6:    out_ratio_o = 4'h3;
      default: out_ratio_o = 4'h6;
    endcase
  end

  assign pll_bypass_o = reference_divider_word == 7'h00;

  // ----------------------------------------
  // Glide and lock timers
  // ----------------------------------------
  logic [31:0] glide_cnt_ff;
  logic [31:0] lock_cnt_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      glide_cnt_ff <= '0;
    end else if (freq_changed) begin
      glide_cnt_ff <= 32'(GLIDE_CYCLES);
    end else if (glide_cnt_ff != '0) begin
      glide_cnt_ff <= glide_cnt_ff - 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_cnt_ff <= '0;
    end else if (cfg_changed) begin
      lock_cnt_ff <= 32'(LOCK_CYCLES);
    end else if (lock_cnt_ff != '0) begin
      lock_cnt_ff <= lock_cnt_ff - 32'h1;
    end
  end

  assign gliding_o = glide_cnt_ff != '0;
  assign locked_o  = lock_cnt_ff == '0;

  // ----------------------------------------
  // Output clocks, digital stand-in for PLL path
  // ----------------------------------------
  logic pri_tick;
  logic pri_lvl;
  logic ref_lvl_ff;
  logic ref_half_ff;
  logic pri_half_ff;
  logic pri_ff;
  logic sec_ff;

  // Divider select change restarts the divider, glitch allowed
  scs_clk_div #(.W(4)) u_out_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i || (cfg_ff[`SCS_OD_HI:`SCS_OD_LO] != output_divide_select)),
    .run_i   (power_down_tristate_n && !pll_bypass_o),
    .ratio_i (out_ratio_o),
    .src_i   (ref_clk_i),
    .tick_o  (pri_tick),
    .lvl_o   (pri_lvl)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_lvl_ff  <= 1'b0;
      ref_half_ff <= 1'b0;
      pri_half_ff <= 1'b0;
    end else begin
      if (ref_clk_i) begin
        ref_lvl_ff <= ~ref_lvl_ff;
      end
      if (ref_clk_i && ref_lvl_ff) begin
        ref_half_ff <= ~ref_half_ff;
      end
      if (pri_tick && pri_lvl) begin
        pri_half_ff <= ~pri_half_ff;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pri_ff <= 1'b0;
      sec_ff <= 1'b0;
    end else begin
      pri_ff <= pll_bypass_o ? ref_lvl_ff : pri_lvl;
      case (scs_second_fn_t'(second_output_function))
        SCS_F_REF:      sec_ff <= ref_lvl_ff;
        SCS_F_REF_HALF: sec_ff <= ref_half_ff;
        SCS_F_OFF:      sec_ff <= 1'b0;
        SCS_F_PRI_HALF: sec_ff <= pll_bypass_o ? ref_lvl_ff : pri_half_ff;
        default:        sec_ff <= 1'b0;
      endcase
    end
  end

  assign primary_clock_out    = pri_ff;
  assign secondary_clock_out  = sec_ff;
  assign primary_clock_oe_o   = power_down_tristate_n;
  assign secondary_clock_oe_o = power_down_tristate_n;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  strobe_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    strobe_rise |=> cfg_ff == $past(shift_ff))
    else $error("strobe did not latch shift word");
  shift_order_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sclk_rise |=> shift_ff[0] == $past(sdata_i) && shift_ff[23:1] == $past(shift_ff[22:0]))
    else $error("shift order wrong");
  strobe_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
    strobe_i && strobe_d_ff && sclk_rise |=> cfg_ff == shift_ff)
    else $error("strobe high pass-through failed");
  latch_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !strobe_i && !$past(strobe_i) |-> $stable(cfg_ff))
    else $error("latch changed without strobe");
  tristate_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !power_down_tristate_n |-> !primary_clock_oe_o && !secondary_clock_oe_o)
    else $error("outputs driven in power-down");
  ratio_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    output_divide_select == 3'h0 |-> out_ratio_o == 4'hA)
    else $error("divider select decode wrong");
  field_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 feedback_divider_word == $past(cfg_ff[15:7]) && reference_divider_word == $past(cfg_ff[6:0]))
    else $error("field layout wrong");
  bypass_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pll_bypass_o |=> primary_clock_out == $past(ref_lvl_ff))
    else $error("bypass does not pass reference");
  sec_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    second_output_function == 2'h2 |=> !secondary_clock_out)
    else $error("secondary off not low");
  glide_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    freq_changed |=> gliding_o)
    else $error("glide not started");
  lock_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_changed |=> !locked_o)
    else $error("lock timer not started");
endmodule

// file: tb/scs_host_model.sv
// Host controller model driving the three-wire programming port
`timescale 1ns/1ps
module scs_host_model (
  input  wire logic clk_i,    // System clock
  output logic      sclk_o,   // Serial clock, idle low
  output logic      sdata_o,  // Serial data
  output logic      strobe_o  // Load strobe
);
  import scs_pkg::*;
  initial begin
    sclk_o   = 1'b0;
    sdata_o  = 1'b0;
    strobe_o = 1'b0;
  end
  // ----------------------------------------
  // Bit, word and strobe sequences
  // ----------------------------------------
  // Data set while clock low, held across the rise, then scrambled
  task automatic shift_bit(input logic b);
    @(posedge clk_i);
    sdata_o <= b;
    @(posedge clk_i);
    sclk_o <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i);
    sclk_o  <= 1'b0;
    sdata_o <= ~b;
  endtask
  // Strobe is left as it stands, normally low
  task automatic shift_word(input scs_word_t w);
    for (int i = 23; i >= 0; i--) begin
      shift_bit(w[i]);
    end
  endtask
  task automatic strobe_pulse();
    @(posedge clk_i);
    strobe_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    strobe_o <= 1'b0;
  endtask
  task automatic strobe_level(input logic lvl);
    @(posedge clk_i);
    strobe_o <= lvl;
  endtask
endmodule

// file: tb/scs_synth_config_tb.sv
// Self-checking bench for the serial clock synthesizer configuration block
`timescale 1ns/1ps
`include "scs_map.svh"
module scs_synth_config_tb;
  import scs_pkg::*;
  localparam int        GLIDE    = 20;
  localparam int        LOCK     = 50;
  localparam int        LIMIT    = 30000;
  localparam int        REF_PER  = 8;
  localparam scs_word_t EX_WORD  = 24'h318A3B;
  localparam scs_word_t BYP_WORD = 24'h018A00;
  logic       clk_i     = 1'b0;
  logic       rst_i     = 1'b1;
  logic       ref_clk_i = 1'b0;
  logic       pd_n      = 1'b1;
  logic       sclk, sdata, strobe;
  scs_word_t  cfg_word, w;
  logic [6:0] ref_div;
  logic [8:0] fb_div;
  scs_odsel_t od_sel;
  logic [3:0] ratio;
  logic [1:0] cload;
  scs_func_t  func;
  logic       duty, bypass, gliding, locked, pri, pri_oe, sec, sec_oe;
  int         mismatches  = 0;
  int         checks_done = 0;
  int         cycles      = 0;
  int         per;
  logic [3:0] ratio_tab [8] = '{4'hA, 4'h2, 4'h8, 4'h4, 4'h5, 4'h7, 4'h3, 4'h6};

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles    <= cycles + 1;
    ref_clk_i <= (cycles[1:0] == 2'h0);
    if (cycles == LIMIT) begin
      mismatches++;
      give_verdict();
    end
  end

  scs_host_model u_scs_host_model (.clk_i(clk_i), .sclk_o(sclk), .sdata_o(sdata), .strobe_o(strobe));
  scs_synth_config #(.GLIDE_CYCLES(GLIDE), .LOCK_CYCLES(LOCK)) u_scs_synth_config (
    .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .sdata_i(sdata), .strobe_i(strobe),
    .power_down_tristate_n(pd_n), .ref_clk_i(ref_clk_i), .cfg_word_o(cfg_word),
    .reference_divider_word(ref_div), .feedback_divider_word(fb_div), .output_divide_select(od_sel),
    .out_ratio_o(ratio), .crystal_load_select(cload), .duty_thresh_o(duty),
    .second_output_function(func), .pll_bypass_o(bypass), .gliding_o(gliding), .locked_o(locked),
    .primary_clock_out(pri), .primary_clock_oe_o(pri_oe), .secondary_clock_out(sec),
    .secondary_clock_oe_o(sec_oe));

  // ----------------------------------------
  // Compare, period measure, load and verdict tasks
  // ----------------------------------------
  task automatic check_vec(input string name, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_bit(input string name, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask
  // Cycles between two rising edges of a clock output
  task automatic period_of(input logic use_sec, output int p);
    logic prev;
    logic cur;
    int   edges;
    int   n;
    int   guard;
    prev  = use_sec ? sec : pri;
    edges = 0;
    n     = 0;
    guard = 0;
    p     = 0;
    while (edges < 2 && guard < 400) begin
      @(posedge clk_i);
      #1;
      guard++;
      cur = use_sec ? sec : pri;
      if (edges > 0) begin
        n++;
      end
      if (cur && !prev) begin
        edges++;
      end
      prev = cur;
    end
    if (edges == 2) begin
      p = n;
    end
  endtask
  task automatic check_fields(input scs_word_t x);
    check_vec("cfg word", x, cfg_word);
    check_vec("ref div", {17'h0, x[`SCS_REF_HI:`SCS_REF_LO]}, {17'h0, ref_div});
    check_vec("fb div", {15'h0, x[`SCS_FB_HI:`SCS_FB_LO]}, {15'h0, fb_div});
    check_vec("out select", {21'h0, x[`SCS_OD_HI:`SCS_OD_LO]}, {21'h0, od_sel});
    check_vec("ratio", {20'h0, ratio_tab[x[`SCS_OD_HI:`SCS_OD_LO]]}, {20'h0, ratio});
    check_vec("function", {22'h0, x[`SCS_FUNC_HI:`SCS_FUNC_LO]}, {22'h0, func});
    check_vec("load", {22'h0, x[`SCS_CLOAD_HI:`SCS_CLOAD_LO]}, {22'h0, cload});
    check_bit("duty", x[`SCS_DUTY_BIT], duty);
    check_bit("bypass", x[`SCS_REF_HI:`SCS_REF_LO] == 7'h00, bypass);
  endtask
  task automatic load(input scs_word_t x);
    u_scs_host_model.shift_word(x);
    u_scs_host_model.strobe_pulse();
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check_fields(`SCS_DEFAULT_WORD);
    check_bit("locked", 1'b1, locked);
    period_of(1'b1, per);
    check_vec("secondary period at power-up", 24'(REF_PER), 24'(per));
    u_scs_host_model.shift_word(EX_WORD);
    #1;
    check_vec("cfg before strobe", `SCS_DEFAULT_WORD, cfg_word);
    u_scs_host_model.strobe_pulse();
    repeat (2) @(posedge clk_i);
    #1;
    check_fields(EX_WORD);
    check_bit("gliding", 1'b1, gliding);
    check_bit("locked", 1'b0, locked);
    repeat (16) begin
      @(posedge clk_i);
      #1;
      check_bit("secondary off", 1'b0, sec);
    end
    repeat (LOCK + 10) @(posedge clk_i);
    #1;
    check_bit("gliding", 1'b0, gliding);
    check_bit("locked", 1'b1, locked);
    for (int i = 0; i < 8; i++) begin
      w = {EX_WORD[23:19], i[2:0], EX_WORD[15:0]};
      load(w);
      check_fields(w);
      check_bit("gliding on select", 1'b0, gliding);
      period_of(1'b0, per);
      check_vec("primary period", 24'(REF_PER * ratio_tab[i]), 24'(per));
    end
    w = {EX_WORD[23:21], 2'h1, EX_WORD[18:0]};
    load(w);
    check_fields(w);
    period_of(1'b1, per);
    check_vec("secondary ref half period", 24'(2 * REF_PER), 24'(per));
    w = {EX_WORD[23:21], 2'h3, EX_WORD[18:0]};
    load(w);
    check_fields(w);
    period_of(1'b1, per);
    check_vec("secondary pri half period", 24'(2 * REF_PER * ratio_tab[EX_WORD[18:16]]), 24'(per));
    repeat (4) u_scs_host_model.shift_bit(1'b1);
    load(`SCS_DEFAULT_WORD);
    check_fields(`SCS_DEFAULT_WORD);
    period_of(1'b1, per);
    check_vec("secondary period default", 24'(REF_PER), 24'(per));
    u_scs_host_model.strobe_level(1'b1);
    u_scs_host_model.shift_word(BYP_WORD);
    repeat (2) @(posedge clk_i);
    #1;
    check_fields(BYP_WORD);
    period_of(1'b0, per);
    check_vec("bypass primary period", 24'(REF_PER), 24'(per));
    period_of(1'b1, per);
    check_vec("bypass secondary period", 24'(REF_PER), 24'(per));
    u_scs_host_model.strobe_level(1'b0);
    @(posedge clk_i);
    pd_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    check_bit("primary oe", 1'b0, pri_oe);
    check_bit("secondary oe", 1'b0, sec_oe);
    check_fields(BYP_WORD);
    load(EX_WORD);
    check_fields(EX_WORD);
    @(posedge clk_i);
    pd_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    check_bit("primary oe", 1'b1, pri_oe);
    check_bit("secondary oe", 1'b1, sec_oe);
    check_fields(EX_WORD);
    period_of(1'b0, per);
    check_vec("primary period after wake", 24'(REF_PER * ratio_tab[EX_WORD[18:16]]), 24'(per));
    give_verdict();
  end
endmodule
